// ===== fbh_ctrl.sv
// Purpose: Host controller that runs flash bank command sequences for software.
// Assumes: AXI4-Lite slave, one write and one read at a time.
// Notes:   Tracks the bank mode itself and refuses commands the mode forbids.
// Behaviour
// - Query entry: two unlocks, bank command.
// - Protection query needs bank and sector address.
// - Secure region entry three, exit four cycles.
// - Word program takes four write cycles.
// - Bypass entry 20h, program A0h then data.
// - Address latched at falling, data rising strobe.
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module fbh_ctrl import fbh_pkg::*; (
  input  wire logic        REF_CLK,
  input  wire logic        RESET_N,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic [22:0]      FLASH_ADDR,
  input  wire logic [15:0] FLASH_DQ_I,
  output logic [15:0]      FLASH_DQ_O,
  output logic [15:0]      FLASH_DQ_OE,
  output logic             FLASH_CE_N,
  output logic             FLASH_WE_N,
  output logic             FLASH_OE_N,
  input  wire logic        FLASH_READY_BUSY_N,
  output logic             FLASH_HWRESET_N,
  output logic             FLASH_ACCEL_HV
);
  // ****************************************************************
  // Reset release and register bus.
  // ****************************************************************
  logic        rst_ff_r, rst_n;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_bus_r, wmask;
  logic        wr_fire, cmd_wr, start;
  logic [31:0] rd_mux;
  logic        rd_hit;

  // Release is synchronised so no flop leaves reset on a different edge.
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_ff_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_ff_r <= 1'b1;
      rst_n    <= rst_ff_r;
    end
  end

  // The write acts once both halves are in, one cycle before bvalid rises.
  assign wr_fire = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
  assign cmd_wr  = wr_fire && awaddr_r == REG_CMD;
  for (genvar b = 0; b < 4; b++) begin : g_mask
    assign wmask[8*b +: 8] = {8{S_AXI_WSTRB[b]}};
  end

  // Write channels are taken in either order and released by the response.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
      awaddr_r      <= '0;
      wdata_bus_r   <= '0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        awaddr_r      <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        wdata_bus_r  <= S_AXI_WDATA & wmask;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_fire) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= awaddr_r > REG_RDATA || awaddr_r[1:0] != 2'h0 ?
                        RESP_SLVERR : RESP_OKAY;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Software registers and flash mode tracking.
  // ****************************************************************
  fbh_op_t     op_r;
  fbh_mode_t   mode_r;
  logic [22:0] addr_r;
  logic [15:0] wdata_r, rdata_r;
  logic        accel_r, hwrst_r, busy_r, done_r, fail_r, refused_r, done_ok, ok;
  fbh_op_t     op_in;

  assign op_in = fbh_op_t'(wdata_bus_r[3:0]);

  // Each command is checked against the mode the bank is believed to be in.
  always_comb begin
    case (op_in)
      OP_READ:      ok = 1'b1;
      OP_RESET:     ok = mode_r != MD_BYPASS;
      OP_QUERY:     ok = mode_r == MD_READ && !accel_r;
      OP_SEC_ENTER: ok = mode_r == MD_READ && !accel_r;
      OP_SEC_EXIT:  ok = mode_r == MD_SECURE;
      OP_PROGRAM:   ok = mode_r == MD_READ && !accel_r;
      OP_BYP_ENTER: ok = mode_r == MD_READ && !accel_r;
      OP_BYP_PROG:  ok = mode_r == MD_BYPASS || accel_r;
      OP_BYP_RESET: ok = mode_r == MD_BYPASS;
      default:      ok = 1'b0;
    endcase
  end
  assign start = cmd_wr && ok && !busy_r && !hwrst_r;

  // Address, data and control registers; the boost pin is refused in secure
  // mode and while secure entry runs, so it never stands in that mode.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      addr_r  <= '0;
      wdata_r <= '0;
      accel_r <= 1'b0;
      hwrst_r <= 1'b0;
    end else if (wr_fire) begin
      if (awaddr_r == REG_ADDR) begin
        addr_r <= wdata_bus_r[22:0];
      end
      if (awaddr_r == REG_WDATA) begin
        wdata_r <= wdata_bus_r[15:0];
      end
      if (awaddr_r == REG_CTRL) begin
        accel_r <= wdata_bus_r[CTRL_ACCEL] && mode_r != MD_SECURE &&
                   !(busy_r && op_r == OP_SEC_ENTER);
        hwrst_r <= wdata_bus_r[CTRL_HWRST];
      end
    end
  end

  // The tracked mode follows completed sequences; a hardware reset restores read.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= MD_READ;
    end else if (hwrst_r) begin
      mode_r <= MD_READ;
    end else if (done_ok) begin
      case (op_r)
        OP_QUERY:     mode_r <= MD_QUERY;
        OP_SEC_ENTER: mode_r <= MD_SECURE;
        OP_SEC_EXIT:  mode_r <= MD_READ;
        OP_BYP_ENTER: mode_r <= MD_BYPASS;
        OP_BYP_RESET: mode_r <= MD_READ;
        OP_RESET:     mode_r <= mode_r == MD_QUERY ? MD_READ : mode_r;
        default:      mode_r <= mode_r;
      endcase
    end
  end

  // ****************************************************************
  // Command sequencer.
  // ****************************************************************
  typedef enum logic [1:0] {SQ_IDLE, SQ_ISSUE, SQ_WAIT} fbh_seq_t;
  fbh_seq_t    sq_r;
  logic [1:0]  step_r, first, last;
  logic        poll_r, fail_seen_r, is_prog, fail_now;
  logic [15:0] code;
  fbh_cyc_if   cyc ();

  assign is_prog = op_r == OP_PROGRAM || op_r == OP_BYP_PROG;
  // Bypass program, bypass reset and reset skip the unlock writes; a read is the final item.
  always_comb begin
    first = op_in == OP_READ ? STEP_FINAL :
            (op_in == OP_RESET || op_in == OP_BYP_PROG || op_in == OP_BYP_RESET) ?
            STEP_CMD : STEP_U1;
    last  = (op_r == OP_RESET || op_r == OP_QUERY || op_r == OP_SEC_ENTER ||
             op_r == OP_BYP_ENTER) ? STEP_CMD : STEP_FINAL;
    case (op_r)
      OP_RESET:                 code = CODE_RESET;
      OP_SEC_ENTER:             code = CODE_SECURE;
      OP_PROGRAM, OP_BYP_PROG:  code = CODE_PROGRAM;
      OP_BYP_ENTER:             code = CODE_BYPASS;
      default:                  code = CODE_QUERY;
    endcase
  end
  assign done_ok = sq_r == SQ_WAIT && cyc.done &&
                   (poll_r ? cyc.rdata[POLL_BIT] == wdata_r[POLL_BIT] :
                    step_r == last && !is_prog);
  assign fail_now = sq_r == SQ_WAIT && cyc.done && poll_r && fail_seen_r &&
                    cyc.rdata[POLL_BIT] != wdata_r[POLL_BIT];

  // Cycle content for the current step; the command cycle carries the bank.
  always_comb begin
    cyc.wr = !(op_r == OP_READ || poll_r);
    case (step_r)
      2'h0: begin
        cyc.addr  = UNLOCK1_ADDR;
        cyc.wdata = UNLOCK1_DATA;
      end
      2'h1: begin
        cyc.addr  = UNLOCK2_ADDR;
        cyc.wdata = UNLOCK2_DATA;
      end
      2'h2: begin
        cyc.addr  = {addr_r[AW-1:BANK_LSB], UNLOCK1_ADDR[BANK_LSB-1:0]};
        cyc.wdata = code;
      end
      default: begin
        cyc.addr  = addr_r;
        cyc.wdata = is_prog ? wdata_r : CODE_ZERO;
      end
    endcase
  end

  // Programs are polled until the data bit matches; a raised failure flag
  // earns one more read, then a reset brings the bank back to the mode the program began in.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sq_r        <= SQ_IDLE;
      op_r        <= OP_READ;
      step_r      <= STEP_U1;
      poll_r      <= 1'b0;
      fail_seen_r <= 1'b0;
      busy_r      <= 1'b0;
      cyc.req     <= 1'b0;
    end else begin
      cyc.req <= 1'b0;
      case (sq_r)
        SQ_IDLE: begin
          if (start) begin
            op_r        <= op_in;
            step_r      <= first;
            poll_r      <= 1'b0;
            fail_seen_r <= 1'b0;
            busy_r      <= 1'b1;
            sq_r        <= SQ_ISSUE;
          end
        end
        SQ_ISSUE: begin
          cyc.req <= 1'b1;
          sq_r    <= SQ_WAIT;
        end
        SQ_WAIT: begin
          if (cyc.done) begin
            sq_r <= SQ_ISSUE;
            if (done_ok) begin
              busy_r <= 1'b0;
              sq_r   <= SQ_IDLE;
            end else if (fail_now) begin
              op_r   <= OP_RESET;
              step_r <= STEP_CMD;
              poll_r <= 1'b0;
            end else if (poll_r) begin
              fail_seen_r <= cyc.rdata[FAIL_BIT];
            end else if (step_r != last) begin
              step_r <= step_r + 2'h1;
            end else begin
              poll_r <= 1'b1;
            end
          end
        end
        default: sq_r <= SQ_IDLE;
      endcase
    end
  end

  // Outcome flags clear when a command is taken; a later event sets them again.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      done_r    <= 1'b0;
      fail_r    <= 1'b0;
      refused_r <= 1'b0;
      rdata_r   <= '0;
    end else begin
      if (start) begin
        done_r    <= 1'b0;
        fail_r    <= 1'b0;
        refused_r <= 1'b0;
      end
      if (cmd_wr && !start) begin
        refused_r <= 1'b1;
      end
      if (fail_now) begin
        fail_r <= 1'b1;
      end
      if (done_ok) begin
        done_r <= 1'b1;
        if (op_r == OP_READ) begin
          rdata_r <= cyc.rdata;
        end
      end
    end
  end

  fbh_cycle u_cycle (
    .clk   (REF_CLK),
    .rst_n (rst_n),
    .cyc   (cyc.eng),
    .dq_i  (FLASH_DQ_I),
    .addr_o(FLASH_ADDR),
    .dq_o  (FLASH_DQ_O),
    .dq_oe (FLASH_DQ_OE),
    .ce_n  (FLASH_CE_N),
    .we_n  (FLASH_WE_N),
    .oe_n  (FLASH_OE_N)
  );

  // ****************************************************************
  // Register read port and pin copies of control bits.
  // ****************************************************************
  always_comb begin
    rd_hit = 1'b1;
    case (S_AXI_ARADDR)
      REG_ADDR:   rd_mux = {9'h000, addr_r};
      REG_WDATA:  rd_mux = {16'h0000, wdata_r};
      REG_CTRL:   rd_mux = {30'h00000000, hwrst_r, accel_r};
      REG_STATUS: rd_mux = {24'h000000, 1'b0, mode_r, FLASH_READY_BUSY_N,
                            refused_r, fail_r, done_r, busy_r};
      REG_RDATA:  rd_mux = {16'h0000, rdata_r};
      REG_CMD:    rd_mux = {28'h0000000, op_r};
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read data is registered, so the answer appears one cycle after arvalid is taken.
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_ARREADY   <= 1'b1;
      S_AXI_RVALID    <= 1'b0;
      S_AXI_RDATA     <= '0;
      S_AXI_RRESP     <= RESP_OKAY;
      FLASH_ACCEL_HV  <= 1'b0;
      FLASH_HWRESET_N <= 1'b0;
    end else begin
      FLASH_ACCEL_HV  <= accel_r;
      FLASH_HWRESET_N <= !hwrst_r;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RDATA   <= rd_mux;
        S_AXI_RRESP   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID  <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n);

  query_mode_gate_a: assert property (cmd_wr && op_in == OP_QUERY && mode_r != MD_READ
    |=> refused_r && $stable(mode_r)) else $error("query accepted outside read");
  secure_hold_a: assert property (mode_r == MD_SECURE && !hwrst_r &&
    !(done_ok && op_r == OP_SEC_EXIT) |=> mode_r == MD_SECURE)
    else $error("secure region left without exit");
  secure_no_accel_a: assert property (mode_r == MD_SECURE |=> !FLASH_ACCEL_HV)
    else $error("boost pin raised in secure mode");
  bypass_exit_only_a: assert property (mode_r == MD_BYPASS && !hwrst_r &&
    !(done_ok && op_r == OP_BYP_RESET) |=> mode_r == MD_BYPASS)
    else $error("bypass left without its reset");
  prog_polls_a: assert property (sq_r == SQ_WAIT && cyc.done && is_prog && !poll_r &&
    step_r == STEP_FINAL |=> poll_r && sq_r == SQ_ISSUE ##1 cyc.req)
    else $error("program not followed by polling");
  query_entry_a: assert property (done_ok && op_r == OP_QUERY |=> mode_r == MD_QUERY)
    else $error("query mode not recorded");
  strobe_data_a: assert property (!FLASH_WE_N |-> !FLASH_CE_N && FLASH_DQ_OE == 16'hffff
    ##1 FLASH_DQ_OE == 16'hffff) else $error("data not held over strobe");
  busy_refuse_a: assert property (cmd_wr && busy_r |=> refused_r && busy_r)
    else $error("command taken while busy");
  fail_reset_a: assert property (fail_now |=> op_r == OP_RESET && step_r == STEP_CMD
    ##1 cyc.req && cyc.wdata == CODE_RESET) else $error("no reset after fail");
  resp_both_a: assert property (wr_fire |=> S_AXI_BVALID)
    else $error("write response missing");

  prog_done_c: cover property (done_ok && op_r == OP_PROGRAM);
  byp_prog_c: cover property (done_ok && op_r == OP_BYP_PROG);
  query_exit_c: cover property (mode_r == MD_QUERY ##[1:200] mode_r == MD_READ);
  fail_path_c: cover property (fail_now);
endmodule

// ===== fbh_pkg.sv
// Purpose: Shared constants and types of the flash bank host controller.
// Assumes: 10 MHz clock, 16-bit flash data, 23-bit word address.
// Notes:   Command codes and unlock cycles are kept here so they can be retuned.
package fbh_pkg;
  // ****************************************************************
  // Clock and bus cycle timing.
  // ****************************************************************
  localparam int         CLK_NS   = 100;
  localparam int         T_WP_NS  = 35;  // Least write strobe low time.
  localparam int         T_ACC_NS = 65;  // Longest read access time.
  localparam logic [3:0] WP_CYC   = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RD_CYC   = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  // ****************************************************************
  // Flash geometry and command constants.
  // ****************************************************************
  localparam int          AW          = 23;
  localparam int          DW          = 16;
  localparam int          BANK_LSB    = 21;
  localparam logic [22:0] UNLOCK1_ADDR = 23'h000555;
  localparam logic [15:0] UNLOCK1_DATA = 16'h00aa;
  localparam logic [22:0] UNLOCK2_ADDR = 23'h0002aa;
  localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [15:0] CODE_RESET   = 16'h00f0;
  localparam logic [15:0] CODE_QUERY   = 16'h0090;
  localparam logic [15:0] CODE_SECURE  = 16'h0088;
  localparam logic [15:0] CODE_PROGRAM = 16'h00a0;
  localparam logic [15:0] CODE_BYPASS  = 16'h0020;
  localparam logic [15:0] CODE_ZERO    = 16'h0000;
  localparam int          POLL_BIT     = 7;  // data_polling_bit
  localparam int          FAIL_BIT     = 5;  // program_fail_flag
  localparam logic [1:0]  STEP_U1      = 2'h0;
  localparam logic [1:0]  STEP_CMD     = 2'h2;
  localparam logic [1:0]  STEP_FINAL   = 2'h3;
  // ****************************************************************
  // Register map, byte offsets on the AXI4-Lite slave.
  // ****************************************************************
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_CTRL   = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA  = 8'h14;
  localparam int         CTRL_ACCEL = 0;
  localparam int         CTRL_HWRST = 1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    OP_READ, OP_RESET, OP_QUERY, OP_SEC_ENTER, OP_SEC_EXIT,
    OP_PROGRAM, OP_BYP_ENTER, OP_BYP_PROG, OP_BYP_RESET
  } fbh_op_t;

  typedef enum logic [1:0] {MD_READ, MD_QUERY, MD_SECURE, MD_BYPASS} fbh_mode_t;
endpackage

// ===== fbh_cyc_if.sv
// Purpose: Carries one flash bus cycle request between sequencer and engine.
// Assumes: req is a one-cycle pulse, done answers it once.
// Notes:   rdata is valid in the cycle that done is high.
`timescale 1ns/1ps
interface fbh_cyc_if;
  logic        req;
  logic        wr;
  logic [22:0] addr;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;
  modport seq (output req, wr, addr, wdata, input done, rdata);
  modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface

// ===== fbh_cycle.sv
// Purpose: Drives one asynchronous write or read cycle on the flash pins.
// Assumes: Flash inputs are synchronous to clk.
// Notes:   Every pin output is a flip-flop.
`timescale 1ns/1ps
module fbh_cycle import fbh_pkg::*; (
  input  wire logic          clk,
  input  wire logic          rst_n,
  fbh_cyc_if.eng             cyc,
  input  wire logic [15:0]   dq_i,
  output logic      [22:0]   addr_o,
  output logic      [15:0]   dq_o,
  output logic      [15:0]   dq_oe,
  output logic               ce_n,
  output logic               we_n,
  output logic               oe_n
);
  typedef enum logic [1:0] {EG_IDLE, EG_SETUP, EG_PULSE, EG_HOLD} fbh_eng_t;
  fbh_eng_t   st_r;
  logic       wr_r;
  logic [3:0] cnt_r;

  // Address settles with chip select before the write strobe falls, and data
  // is still driven when the strobes rise, so both latch points see it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= EG_IDLE;
      wr_r      <= 1'b0;
      cnt_r     <= 4'h0;
      addr_o    <= '0;
      dq_o      <= '0;
      dq_oe     <= '0;
      ce_n      <= 1'b1;
      we_n      <= 1'b1;
      oe_n      <= 1'b1;
      cyc.done  <= 1'b0;
      cyc.rdata <= '0;
    end else begin
      cyc.done <= 1'b0;
      case (st_r)
        EG_IDLE: begin
          if (cyc.req) begin
            addr_o <= cyc.addr;
            dq_o   <= cyc.wdata;
            dq_oe  <= {16{cyc.wr}};
            ce_n   <= 1'b0;
            oe_n   <= cyc.wr;
            wr_r   <= cyc.wr;
            st_r   <= EG_SETUP;
          end
        end
        EG_SETUP: begin
          we_n  <= ~wr_r;
          cnt_r <= wr_r ? WP_CYC - 4'h1 : RD_CYC - 4'h1;
          st_r  <= EG_PULSE;
        end
        EG_PULSE: begin
          if (cnt_r == 4'h0) begin
            if (!wr_r) begin
              cyc.rdata <= dq_i;
            end
            we_n <= 1'b1;
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            st_r <= EG_HOLD;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        EG_HOLD: begin
          dq_oe    <= '0;
          cyc.done <= 1'b1;
          st_r     <= EG_IDLE;
        end
        default: st_r <= EG_IDLE;
      endcase
    end
  end
endmodule

// ===== fbh_flash_model.sv
// Purpose: Behavioural flash bank that answers the controller's pins.
// Assumes: Sixteen words of array are enough, aliased by low address bits.
// Notes:   An undriven bus shows the inverse of the last value read.
`timescale 1ns/1ps
module fbh_flash_model import fbh_pkg::*; #(
  parameter logic [15:0] QCODE = 16'h1234,  // Arbitrary value.
  parameter logic [15:0] SCODE = 16'h5e00
) (
  input  wire logic        clk,
  input  wire logic [22:0] a,
  input  wire logic [15:0] d,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        hw_n,
  input  wire logic        acc,
  output logic      [15:0] q,
  output logic             rb_n
);
  logic [15:0] mem [16];
  logic [15:0] pd, last;
  logic [22:0] la;
  logic [3:0]  pa;
  logic [2:0]  st;
  logic        qry, sec, byp, fl, wsel;
  int          busy;
  // Power-up state is array reading.
  initial begin
    foreach (mem[i]) mem[i] = 16'hffff;
    {st, qry, sec, byp, fl, last} = '0;
    busy = 0;
  end
  // Address and select are captured as the strobe falls, data as it rises.
  // Select may rise together with the strobe, so it is not looked at then.
  always @(negedge we_n) begin
    la   = a;
    wsel = !ce_n;
  end
  // Command decoder, blind while an algorithm runs.
  always @(posedge we_n) if (wsel) begin
    if (fl && d == CODE_RESET) begin
      fl = 1'b0;
      busy = 0;
    end else if (busy == 0) begin
      if (st == 3'd3) begin
        pd = d;
        pa = la[3:0];
        busy = 5;
        st = 3'd0;
        fl = |(d & ~mem[la[3:0]]);
      end else if (st == 3'd5) begin
        if (d == CODE_ZERO) {sec, byp} = 2'b00;
        st = 3'd0;
      end else if (d == CODE_RESET && !byp) begin
        qry = 1'b0;
        st = 3'd0;
      end else if (byp || acc) begin
        st = d == CODE_PROGRAM ? 3'd3 : d == CODE_QUERY ? 3'd5 : 3'd0;
      end else if (st == 3'd0) begin
        st = (la == UNLOCK1_ADDR && d == UNLOCK1_DATA) ? 3'd1 : 3'd0;
      end else if (st == 3'd1) begin
        st = (la == UNLOCK2_ADDR && d == UNLOCK2_DATA) ? 3'd2 : 3'd0;
      end else begin
        st = sec && d == CODE_QUERY ? 3'd5 : d == CODE_PROGRAM ? 3'd3 : 3'd0;
        qry |= d == CODE_QUERY && !sec;
        sec |= d == CODE_SECURE;
        byp |= d == CODE_BYPASS && !sec;
      end
    end
  end
  // Algorithm timer; a failed program hangs until a reset command.
  // It runs on the falling edge so the controller never samples a race.
  always @(negedge clk) begin
    if (!hw_n) begin
      {busy, fl, st, qry, sec, byp} = '0;
    end else if (busy > 0 && !fl) begin
      busy--;
      if (busy == 0) mem[pa] &= pd;
    end
    if (!ce_n && !oe_n) last = q;
  end
  // Status replaces query and secure data while busy.
  always_comb begin
    q = (ce_n || oe_n) ? ~last : busy != 0 ? {8'h00, ~pd[7], 1'b0, fl, 5'h00} :
        qry ? QCODE : sec ? (SCODE | 16'(a[2:0])) : mem[a[3:0]];
  end
  assign rb_n = busy == 0;
endmodule

// ===== flash_bank_command_modes_bench.sv
// Purpose: Self-checking bench of the flash bank host controller.
// Assumes: Model answers on the controller's flash pins.
// Notes:   Status compares pack {ready, fail, refused, mode}.
`timescale 1ns/1ps
module flash_bank_command_modes_bench import fbh_pkg::*;;
  `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %0t %m got %h exp %h", $time, g, e); end end
  localparam logic [15:0] QC = 16'h1234;
  localparam logic [15:0] SC = 16'h5e00;
  logic REF_CLK = 0, RESET_N = 0, S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
  logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_ARREADY, S_AXI_RVALID, FLASH_CE_N, FLASH_WE_N, FLASH_OE_N, FLASH_READY_BUSY_N;
  logic FLASH_HWRESET_N, FLASH_ACCEL_HV;
  logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
  logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [22:0] FLASH_ADDR;
  logic [15:0] FLASH_DQ_I, FLASH_DQ_O, FLASH_DQ_OE;
  int num_errors = 0, n_checks = 0;
  logic [31:0] s;
  fbh_ctrl fbh_ctrl_i (.*);
  fbh_flash_model #(.QCODE(QC), .SCODE(SC)) fbh_flash_model_i (.clk(REF_CLK), .a(FLASH_ADDR),
    .d(FLASH_DQ_O), .ce_n(FLASH_CE_N), .we_n(FLASH_WE_N), .oe_n(FLASH_OE_N),
    .hw_n(FLASH_HWRESET_N), .acc(FLASH_ACCEL_HV), .q(FLASH_DQ_I), .rb_n(FLASH_READY_BUSY_N));
  always #50 REF_CLK = ~REF_CLK;
  // ****************************************************************
  // Bus tasks.
  // ****************************************************************
  // Address and data go out together; each is released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge REF_CLK);
    {S_AXI_AWADDR, S_AXI_WDATA} <= {a, d};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'b111;
    while (S_AXI_BVALID !== 1'b1) begin
      @(posedge REF_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end
    `CHK(S_AXI_BRESP, r)
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] r);
    @(posedge REF_CLK);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'b11;
    while (S_AXI_RVALID !== 1'b1) begin
      @(posedge REF_CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end
    v = S_AXI_RDATA;
    `CHK(S_AXI_RRESP, r)
    S_AXI_RREADY <= 1'b0;
  endtask
  // Runs one command to completion and judges the status it leaves.
  task automatic op(input fbh_op_t o, input logic [22:0] a, input logic [15:0] d,
                    input logic [3:0] e);
    wr(REG_ADDR, 32'(a), RESP_OKAY);
    wr(REG_WDATA, 32'(d), RESP_OKAY);
    wr(REG_CMD, 32'(o), RESP_OKAY);
    do begin
      rd(REG_STATUS, s, RESP_OKAY);
    end while (s[0] !== 1'b0);
    `CHK({s[4], s[2], s[3], s[6:5]}, {1'b1, e})
  endtask
  task automatic rdv(input logic [22:0] a, input logic [15:0] e, input logic [1:0] md);
    op(OP_READ, a, 16'h0000, {2'b00, md});
    rd(REG_RDATA, s, RESP_OKAY);
    `CHK(s[15:0], e)
  endtask
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_prog;
    rdv(23'h3, 16'hffff, 2'd0);
    wr(8'h18, 32'h0, RESP_SLVERR);
    rd(8'h18, s, RESP_SLVERR);
    op(OP_PROGRAM, 23'h3, 16'ha5a5, 4'b0000);
    rdv(23'h3, 16'ha5a5, 2'd0);
    op(OP_PROGRAM, 23'h3, 16'h00ff, 4'b1000);
    rdv(23'h3, 16'ha5a5, 2'd0);
  endtask
  task automatic t_query;
    op(OP_QUERY, 23'h0, 16'h0, 4'b0001);
    rdv(23'h9, QC, 2'd1);
    rdv(23'h2, QC, 2'd1);
    op(OP_PROGRAM, 23'h3, 16'h0, 4'b0101);
    op(OP_RESET, 23'h0, 16'h0, 4'b0000);
    rdv(23'h3, 16'ha5a5, 2'd0);
  endtask
  task automatic t_secure;
    op(OP_SEC_ENTER, 23'h0, 16'h0, 4'b0010);
    rdv(23'h4, SC | 16'h4, 2'd2);
    op(OP_BYP_ENTER, 23'h0, 16'h0, 4'b0110);
    op(OP_QUERY, 23'h0, 16'h0, 4'b0110);
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    rd(REG_CTRL, s, RESP_OKAY);
    `CHK(s[0], 1'b0)
    op(OP_SEC_EXIT, 23'h0, 16'h0, 4'b0000);
    rdv(23'h3, 16'ha5a5, 2'd0);
  endtask
  task automatic t_bypass;
    op(OP_BYP_ENTER, 23'h0, 16'h0, 4'b0011);
    wr(REG_ADDR, 32'h5, RESP_OKAY);
    wr(REG_WDATA, 32'h0f0f, RESP_OKAY);
    wr(REG_CMD, 32'(OP_BYP_PROG), RESP_OKAY);
    op(OP_READ, 23'h5, 16'h0f0f, 4'b0111);
    op(OP_RESET, 23'h0, 16'h0, 4'b0111);
    op(OP_BYP_RESET, 23'h0, 16'h0, 4'b0000);
    rdv(23'h5, 16'h0f0f, 2'd0);
  endtask
  task automatic t_accel;
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    op(OP_PROGRAM, 23'h6, 16'h0, 4'b0100);
    op(OP_BYP_PROG, 23'h6, 16'h1234, 4'b0000);
    wr(REG_CTRL, 32'h2, RESP_OKAY);
    @(posedge REF_CLK);
    `CHK({FLASH_HWRESET_N, FLASH_ACCEL_HV}, 2'b00)
    op(OP_READ, 23'h0, 16'h0, 4'b0100);
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    rdv(23'h6, 16'h1234, 2'd0);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Reset is held six cycles, then the scenarios run in turn.
  initial begin
    repeat (6) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    t_prog();
    t_query();
    t_secure();
    t_bypass();
    t_accel();
    final_report();
  end
  // Watchdog sized well beyond the expected run.
  initial begin
    #4000000;
    num_errors++;
    final_report();
  end
endmodule
